// *** rtl/serial_consts.vh ***
// Purpose: shared offsets, field positions, reset values and codes of the serial channel
// Assumes: included by bare name from the design files
// Notes:   byte addresses on the register bus, one aligned 32-bit word each
`ifndef SERIAL_CONSTS_VH
`define SERIAL_CONSTS_VH

// ----------------------------------------------------------------------------
// register word offsets (address bits 4:2)
// ----------------------------------------------------------------------------
`define OFS_MODE        3'h0
`define OFS_TX_SHIFT    3'h1
`define OFS_RX_BUFFER   3'h2
`define OFS_RX_STATUS   3'h3
`define OFS_BAUD        3'h4
`define OFS_FLAGS       3'h5

// ----------------------------------------------------------------------------
// serial_mode_reg fields
// ----------------------------------------------------------------------------
`define MODE_RX_EN      6
`define MODE_PAR_HI     5
`define MODE_PAR_LO     4
`define MODE_CHAR8      3
`define MODE_STOP2      2
`define MODE_ERR_MASK   1
`define MODE_RESET      8'h08

`define PAR_NONE        2'h0
`define PAR_ZERO        2'h1
`define PAR_ODD         2'h2
`define PAR_EVEN        2'h3

// ----------------------------------------------------------------------------
// baud_gen_ctrl fields: divisor k, prescale exponent m, external clock select
// ----------------------------------------------------------------------------
`define BAUD_K_HI       7
`define BAUD_M_HI       11
`define BAUD_M_LO       8
`define BAUD_EXT        15
`define BAUD_RESET      16'h0008
`define BAUD_M_MAX      4'h9

// ----------------------------------------------------------------------------
// rx_status_reg and flag register bits
// ----------------------------------------------------------------------------
`define STAT_OVERRUN    0
`define STAT_FRAMING    1
`define STAT_PARITY     2

`define FLAG_TX_DONE    0
`define FLAG_RX_DONE    1
`define FLAG_TX_BUSY    2
`define FLAG_RX_FULL    3

`endif

// *** rtl/baud_prescale.v ***
// Purpose: source tick of the bit counters, 2^(m+1) main clocks or an external serial clock
// Assumes: external serial clock is far slower than sys_clk
// Notes:   hold freezes the internal tick only; the external clock keeps running
`timescale 1ns/1ps
`default_nettype none
`include "serial_consts.vh"

module baud_prescale (
    input  wire       sys_clk,
    input  wire       rst_n,
    input  wire [3:0] scale_exp,
    input  wire       ext_sel,
    input  wire       ext_clk_pin,
    input  wire       hold,
    output reg        tick
);
    reg  [10:0] div_cnt;
    reg         ext_meta;
    reg         ext_sync;
    reg         ext_prev;
    wire [3:0]  m_eff  = (scale_exp > `BAUD_M_MAX) ? `BAUD_M_MAX : scale_exp;
    wire [10:0] last   = (11'h002 << m_eff) - 11'h001;

    // ------------------------------------------------------------------------
    // prescaler and external clock edge
    // ------------------------------------------------------------------------
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt  <= 11'h000;
            ext_meta <= 1'b0;
            ext_sync <= 1'b0;
            ext_prev <= 1'b0;
            tick     <= 1'b0;
        end else begin
            ext_meta <= ext_clk_pin;
            ext_sync <= ext_meta;
            ext_prev <= ext_sync;
            if (ext_sel) begin
                div_cnt <= 11'h000;
                tick    <= ext_sync & ~ext_prev;
            end else if (hold) begin
                tick    <= 1'b0;
            end else if (div_cnt >= last) begin
                div_cnt <= 11'h000;
                tick    <= 1'b1;
            end else begin
                div_cnt <= div_cnt + 11'h001;
                tick    <= 1'b0;
            end
        end
    end
endmodule // baud_prescale

`default_nettype wire

// *** rtl/async_serial.v ***
// Purpose: transmit, receive and error reporting of one asynchronous serial channel
// Assumes: Avalon-MM slave with waitrequest, byte addresses, one word per register
// Notes:   all serial timing advances only on the prescaler tick
//
// How it works
// - zero parity always sends a 0 parity bit
// - zero parity never checks the received parity
// - no parity: no bit sent, expected, or flagged
// - writing the character starts a full framed transmission
// - frame shifted out raises done pulse and flag
// - receiver runs only while enable bit 6 set
// - falling line, half bit, low confirms start
// - take character, optional parity, one stop bit
// - frame end copies data, raises receive done
// - faulty frames still reach the receive buffer
// - error frames interrupt only when mask bit 1 clear
// - clearing enable aborts reception, nothing changes
// - parity, framing, overrun each own status flag
// - status clears on buffer read or next frame
// - parity mismatch with configured type sets parity flag
// - missing stop bit sets framing flag
// - unread buffer at next frame sets overrun 01H
// - halt with external clock: transfers carry on
// - stopped internal clock freezes all state and pin
// - even or odd parity generated and checked
// - seven-bit characters drop bit 7, read zero
//
// Design decisions made here: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
`include "serial_consts.vh"

module async_serial (
    input  wire        sys_clk,
    input  wire        rst_n,
    input  wire [4:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    input  wire [3:0]  avs_byteenable,
    output reg  [31:0] avs_readdata,
    output wire        avs_waitrequest,
    input  wire        rx_line_pin,
    input  wire        ext_serial_clk,
    input  wire        clock_hold,
    output reg         tx_line_pin,
    output reg         tx_done_irq,
    output reg         rx_done_irq
);
    localparam RX_IDLE  = 2'h0;
    localparam RX_START = 2'h1;
    localparam RX_DATA  = 2'h2;

    reg  [7:0]  serial_mode_reg;
    reg  [15:0] baud_gen_ctrl;
    reg  [7:0]  tx_shift_reg;
    reg  [12:0] tx_frame;
    reg  [3:0]  tx_left;
    reg  [7:0]  tx_cnt;
    reg         tx_busy;
    reg         tx_done_irq_flag;
    reg  [1:0]  rx_state;
    reg  [7:0]  rx_cnt;
    reg  [3:0]  rx_idx;
    reg  [8:0]  rx_sh;
    reg         rx_prev;
    reg         rx_meta;
    reg         rx_sync;
    reg  [7:0]  rx_buffer_reg;
    reg  [2:0]  rx_status_reg;
    reg         rx_full;
    reg         rx_done_flag;
    reg         ack;
    reg  [31:0] next_readdata;
    wire        tick;

    // ------------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------------
    // character length in bits
    function [3:0] char_len;
        input char8;
        begin
            char_len = char8 ? 4'h8 : 4'h7;
        end
    endfunction

    // parity bit to send for a masked character
    function par_bit;
        input [7:0] data;
        input [1:0] mode;
        begin
            case (mode)
                `PAR_EVEN: par_bit = ^data;
                `PAR_ODD:  par_bit = ~(^data);
                default:   par_bit = 1'b0;
            endcase
        end
    endfunction

    // full line frame, start bit in bit 0, idle ones above the stop bits
    function [12:0] build_frame;
        input [7:0] data;
        input [3:0] nchar;
        input [1:0] mode;
        integer i;
        begin
            build_frame = 13'h1FFF;
            build_frame[0] = 1'b0;
            for (i = 0; i < 8; i = i + 1) begin
                if (i < nchar)
                    build_frame[i + 1] = data[i];
            end
            if (mode != `PAR_NONE)
                build_frame[nchar + 4'h1] = par_bit(data, mode);
        end
    endfunction

    wire [3:0] nchar   = char_len(serial_mode_reg[`MODE_CHAR8]);
    wire [1:0] par_md  = serial_mode_reg[`MODE_PAR_HI:`MODE_PAR_LO];
    wire       par_on  = (par_md != `PAR_NONE);
    wire       rx_en   = serial_mode_reg[`MODE_RX_EN];
    wire [7:0] k_div   = (baud_gen_ctrl[`BAUD_K_HI:0] == 8'h00) ? 8'h01 : baud_gen_ctrl[`BAUD_K_HI:0];
    wire [7:0] k_half  = (k_div[7:1] == 7'h00) ? 8'h01 : {1'b0, k_div[7:1]};
    wire [7:0] char_mask = serial_mode_reg[`MODE_CHAR8] ? 8'hFF : 8'h7F;
    wire [3:0] tx_count = 4'h1 + nchar + {3'h0, par_on} + (serial_mode_reg[`MODE_STOP2] ? 4'h2 : 4'h1);
    wire [3:0] rx_last  = nchar + {3'h0, par_on};

    // ------------------------------------------------------------------------
    // bus slave: one wait state, then readdata and write effect together
    // ------------------------------------------------------------------------
    wire       req    = avs_read | avs_write;
    wire [2:0] sel    = avs_address[4:2];
    wire       wr     = ack & avs_write;
    wire       rd     = ack & avs_read;
    wire       lane0  = avs_byteenable[0];
    wire       lane1  = avs_byteenable[1];
    wire       wr_tx  = wr & (sel == `OFS_TX_SHIFT) & lane0;
    wire       rd_buf = rd & (sel == `OFS_RX_BUFFER);
    wire       wr_flg = wr & (sel == `OFS_FLAGS) & lane0;

    assign avs_waitrequest = req & ~ack;

    always @* begin
        next_readdata = 32'h0000_0000;
        case (sel)
            `OFS_MODE:      next_readdata[7:0]  = serial_mode_reg;
            `OFS_TX_SHIFT:  next_readdata[7:0]  = tx_shift_reg;
            `OFS_RX_BUFFER: next_readdata[7:0]  = rx_buffer_reg;
            `OFS_RX_STATUS: next_readdata[2:0]  = rx_status_reg;
            `OFS_BAUD:      next_readdata[15:0] = baud_gen_ctrl;
            `OFS_FLAGS:     next_readdata[3:0]  = {rx_full, tx_busy, rx_done_flag, tx_done_irq_flag};
            default:        next_readdata = 32'h0000_0000;
        endcase
    end

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ack             <= 1'b0;
            avs_readdata    <= 32'h0000_0000;
            serial_mode_reg <= `MODE_RESET;
            baud_gen_ctrl   <= `BAUD_RESET;
        end else begin
            ack <= req & ~ack;
            if (avs_read & ~ack)
                avs_readdata <= next_readdata;
            // mode writes mid-frame are software's to avoid; the transmit frame already
            // built keeps going, while the receiver applies the new format at once
            if (wr & (sel == `OFS_MODE) & lane0)
                serial_mode_reg <= avs_writedata[7:0] & 8'h7E;
            if (wr & (sel == `OFS_BAUD) & lane0)
                baud_gen_ctrl[7:0] <= avs_writedata[7:0];
            if (wr & (sel == `OFS_BAUD) & lane1)
                baud_gen_ctrl[15:8] <= avs_writedata[15:8] & 8'h8F;
        end
    end

    // ------------------------------------------------------------------------
    // bit clock source
    // ------------------------------------------------------------------------
    baud_prescale u_prescale (
        .sys_clk     (sys_clk),
        .rst_n       (rst_n),
        .scale_exp   (baud_gen_ctrl[`BAUD_M_HI:`BAUD_M_LO]),
        .ext_sel     (baud_gen_ctrl[`BAUD_EXT]),
        .ext_clk_pin (ext_serial_clk),
        .hold        (clock_hold),
        .tick        (tick)
    );

    // ------------------------------------------------------------------------
    // transmitter
    // ------------------------------------------------------------------------
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_shift_reg     <= 8'h00;
            tx_frame         <= 13'h1FFF;
            tx_left          <= 4'h0;
            tx_cnt           <= 8'h00;
            tx_busy          <= 1'b0;
            tx_line_pin      <= 1'b1;
            tx_done_irq      <= 1'b0;
            tx_done_irq_flag <= 1'b0;
        end else begin
            tx_done_irq <= 1'b0;
            if (wr_flg & avs_writedata[`FLAG_TX_DONE])
                tx_done_irq_flag <= 1'b0;
            if (!tx_busy) begin
                // a write while busy is dropped: the frame in flight has priority
                if (wr_tx) begin
                    tx_shift_reg <= avs_writedata[7:0];
                    tx_frame     <= build_frame(avs_writedata[7:0] & char_mask, nchar, par_md) >> 1;
                    tx_left      <= tx_count - 4'h1;
                    tx_cnt       <= 8'h00;
                    tx_busy      <= 1'b1;
                    tx_line_pin  <= 1'b0;
                end
            end else if (tick) begin
                // without a tick the pin and counters hold their level
                if (tx_cnt >= k_div - 8'h01) begin
                    tx_cnt <= 8'h00;
                    if (tx_left == 4'h0) begin
                        tx_busy          <= 1'b0;
                        tx_line_pin      <= 1'b1;
                        tx_done_irq      <= 1'b1;
                        tx_done_irq_flag <= 1'b1;
                    end else begin
                        tx_line_pin <= tx_frame[0];
                        tx_frame    <= {1'b1, tx_frame[12:1]};
                        tx_left     <= tx_left - 4'h1;
                    end
                end else begin
                    tx_cnt <= tx_cnt + 8'h01;
                end
            end
        end
    end

    // ------------------------------------------------------------------------
    // receiver
    // ------------------------------------------------------------------------
    wire [7:0] rx_char  = rx_sh[7:0] & char_mask;
    wire       rx_par   = rx_sh[nchar];
    wire       err_par  = par_on & (par_md != `PAR_ZERO) &
                          ((^{rx_char, rx_par}) ^ (par_md == `PAR_ODD));
    wire       err_frm  = ~rx_sync;
    wire       err_ovr  = rx_full & ~rd_buf;
    wire       rx_end   = (rx_state == RX_DATA) & tick & rx_en &
                          (rx_cnt >= k_div - 8'h01) & (rx_idx == rx_last);
    wire       any_err  = err_par | err_frm | err_ovr;

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_meta  <= 1'b1;
            rx_sync  <= 1'b1;
        end else begin
            rx_meta  <= rx_line_pin;
            rx_sync  <= rx_meta;
        end
    end

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_state <= RX_IDLE;
            rx_cnt   <= 8'h00;
            rx_idx   <= 4'h0;
            rx_sh    <= 9'h000;
            rx_prev  <= 1'b1;
        end else if (!rx_en) begin
            rx_state <= RX_IDLE;
            rx_cnt   <= 8'h00;
            rx_prev  <= 1'b1;
        end else if (tick) begin
            // partial frames survive a frozen tick and resume with it
            rx_prev <= rx_sync;
            case (rx_state)
                RX_IDLE: begin
                    if (rx_prev & ~rx_sync) begin
                        rx_state <= RX_START;
                        rx_cnt   <= 8'h00;
                    end
                end
                RX_START: begin
                    if (rx_cnt >= k_half - 8'h01) begin
                        rx_cnt <= 8'h00;
                        rx_idx <= 4'h0;
                        // a high level here was a glitch, not a start bit
                        rx_state <= rx_sync ? RX_IDLE : RX_DATA;
                    end else begin
                        rx_cnt <= rx_cnt + 8'h01;
                    end
                end
                RX_DATA: begin
                    if (rx_cnt >= k_div - 8'h01) begin
                        rx_cnt <= 8'h00;
                        if (rx_idx == rx_last) begin
                            rx_state <= RX_IDLE;
                        end else begin
                            rx_sh[rx_idx] <= rx_sync;
                            rx_idx        <= rx_idx + 4'h1;
                        end
                    end else begin
                        rx_cnt <= rx_cnt + 8'h01;
                    end
                end
                default: rx_state <= RX_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // receive buffer, status and completion
    // ------------------------------------------------------------------------
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_buffer_reg <= 8'h00;
            rx_status_reg <= 3'h0;
            rx_full       <= 1'b0;
            rx_done_flag  <= 1'b0;
            rx_done_irq   <= 1'b0;
        end else begin
            rx_done_irq <= 1'b0;
            if (wr_flg & avs_writedata[`FLAG_RX_DONE])
                rx_done_flag <= 1'b0;
            if (rx_end) begin
                // completion beats a buffer read in the same cycle
                rx_buffer_reg <= rx_char;
                rx_status_reg <= {err_par, err_frm, err_ovr};
                rx_full       <= 1'b1;
                if (!any_err || !serial_mode_reg[`MODE_ERR_MASK]) begin
                    rx_done_irq  <= 1'b1;
                    rx_done_flag <= 1'b1;
                end
            end else if (rd_buf) begin
                // status must be read before this clears it
                rx_status_reg <= 3'h0;
                rx_full       <= 1'b0;
            end
        end
    end
endmodule // async_serial

`default_nettype wire

// *** sim/async_serial_assertions.sv ***
// Purpose: port-level checks of the serial channel
// Assumes: bound to async_serial, one clock domain
// Notes:   read data is judged in the cycle waitrequest is low
`timescale 1ns/1ps
`default_nettype none
module async_serial_assertions (
    input wire logic        sys_clk,
    input wire logic        rst_n,
    input wire logic [4:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        tx_line_pin,
    input wire logic        tx_done_irq,
    input wire logic        rx_done_irq
);
    // ----------
    // handshake and outputs
    // ----------
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    wire req    = avs_read | avs_write;
    wire rd_ack = avs_read & ~avs_waitrequest;

    wait_first_a: assert property ($rose(req) |-> avs_waitrequest)
        else $error("request answered without a wait cycle");
    one_wait_a: assert property ($rose(req) |=> !avs_waitrequest)
        else $error("more than one wait cycle");
    idle_nowait_a: assert property (!req |-> !avs_waitrequest)
        else $error("waitrequest high while idle");
    unmapped_zero_a: assert property (rd_ack && avs_address[4:2] > 3'h5 |-> avs_readdata == 32'h0)
        else $error("unmapped word read nonzero");
    mode_bits_a: assert property (rd_ack && avs_address[4:2] == 3'h0 |-> (avs_readdata & 32'hFFFFFF81) == 32'h0)
        else $error("mode reserved bits nonzero");
    stat_bits_a: assert property (rd_ack && avs_address[4:2] == 3'h3 |-> avs_readdata[31:3] == 29'h0)
        else $error("status unused bits nonzero");
    tx_pulse_a: assert property (tx_done_irq |=> !tx_done_irq)
        else $error("transmit done longer than one cycle");
    rx_pulse_a: assert property (rx_done_irq |=> !rx_done_irq)
        else $error("receive done longer than one cycle");
    tx_stop_a: assert property (tx_done_irq |-> tx_line_pin && $past(tx_line_pin, 2))
        else $error("transmit done without stop level");

    tx_done_c: cover property (tx_done_irq);
    rx_done_c: cover property (rx_done_irq);
    unmapped_c: cover property (rd_ack && avs_address[4:2] > 3'h5);
endmodule // async_serial_assertions
`default_nettype wire

// *** sim/serial_peer.sv ***
// Purpose: remote transceiver: sends frames, captures transmitted ones
// Assumes: bit time BIT clocks, line idles high
// Notes:   capture samples mid-bit, first data bit one and a half bits after the falling edge
`timescale 1ns/1ps
`default_nettype none
module serial_peer #(parameter int BIT = 16) (
    input  wire logic       clk,
    input  wire logic       tx_line,
    input  wire logic [3:0] nbits,
    output var  logic       rx_line,
    output var  logic [10:0] got,
    output var  logic       got_stb
);
    // ----------
    // send and capture
    // ----------
    initial begin
        rx_line = 1'b1;
        got_stb = 1'b0;
        got = 11'h0;
    end

    task automatic send(input logic [11:0] bits, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            rx_line <= bits[i];
            repeat (BIT - 1) @(posedge clk);
        end
        @(posedge clk);
        rx_line <= 1'b1;
    endtask

    initial forever begin
        @(negedge tx_line);
        got = 11'h0;
        repeat (BIT / 2) @(posedge clk);
        for (int i = 0; i < nbits; i++) begin
            repeat (BIT) @(posedge clk);
            got[i] = tx_line;
        end
        got_stb <= 1'b1;
        @(posedge clk);
        got_stb <= 1'b0;
    end
endmodule // serial_peer
`default_nettype wire

// *** sim/tb_async_serial_tx_rx_errors.sv ***
// Purpose: self-checking bench of the serial channel
// Assumes: k=8 m=0, so one bit is 16 clocks
// Notes:   reads and frames are checked from queues
`timescale 1ns/1ps
`default_nettype none
bind async_serial async_serial_assertions chk_u (
    .sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .tx_line_pin(tx_line_pin), .tx_done_irq(tx_done_irq), .rx_done_irq(rx_done_irq));
module tb_async_serial_tx_rx_errors;
    logic        sys_clk, rst_n, avs_read, avs_write, avs_waitrequest;
    logic        rx_line_pin, tx_line_pin, tx_done_irq, rx_done_irq, got_stb, hold, ext_clk;
    logic [4:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic [3:0]  nbits;
    logic [10:0] got;
    logic [7:0]  d;
    logic [31:0] rdq[$];
    logic [10:0] txq[$];
    int          error_cnt = 0, n_tests = 0, tx_irqs = 0, rx_irqs = 0, c;

    async_serial dut_u (
        .sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .rx_line_pin(rx_line_pin),
        .ext_serial_clk(ext_clk), .clock_hold(hold), .tx_line_pin(tx_line_pin),
        .tx_done_irq(tx_done_irq), .rx_done_irq(rx_done_irq));
    serial_peer #(.BIT(16)) peer_u (
        .clk(sys_clk), .tx_line(tx_line_pin), .nbits(nbits), .rx_line(rx_line_pin),
        .got(got), .got_stb(got_stb));

    // ----------
    // helpers
    // ----------
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    // free-running external bit clock, one rising edge every two sys_clk cycles
    initial begin
        ext_clk = 1'b0;
        forever @(posedge sys_clk) ext_clk <= ~ext_clk;
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d errors %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic bus(input logic [4:0] a, input logic w, input logic [31:0] v);
        @(posedge sys_clk);
        avs_address   <= a;
        avs_read      <= ~w;
        avs_write     <= w;
        avs_writedata <= v;
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic wr(input logic [4:0] a, input logic [31:0] v);
        bus(a, 1'b1, v);
    endtask

    task automatic rd(input logic [4:0] a, input logic [31:0] e);
        rdq.push_back(e);
        bus(a, 1'b0, 32'h0);
    endtask

    // bits after the start bit: data LSB first, parity if any, one stop
    function automatic logic [10:0] frame(input logic [7:0] v, input logic [1:0] p,
                                          input logic c8, output int n);
        logic [7:0] dd;
        int         nb;
        dd = c8 ? v : {1'b0, v[6:0]};
        nb = c8 ? 8 : 7;
        frame = {3'h0, dd};
        if (p != 2'h0) frame[nb] = (p == 2'h1) ? 1'b0 : (p == 2'h2) ? ~^dd : ^dd;
        n = nb + ((p != 2'h0) ? 1 : 0) + 1;
        frame[n - 1] = 1'b1;
    endfunction

    task automatic tx_case(input logic [7:0] v, input logic [1:0] p, input logic c8);
        int n;
        int k;
        txq.push_back(frame(v, p, c8, n));
        nbits <= n[3:0];
        k = tx_irqs;
        wr(5'h04, {24'h0, v});
        // mode stays untouched until the frame is out
        for (int i = 0; i < 400 && tx_irqs == k; i++) @(posedge sys_clk);
        chk("tx_done", 32'(tx_irqs - k), 32'h1);
    endtask

    task automatic rx_send(input logic [7:0] v, input logic [1:0] p, input logic c8, input logic [10:0] flip);
        int n;
        logic [10:0] f;
        f = frame(v, p, c8, n);
        peer_u.send({f ^ flip, 1'b0}, n + 1);
    endtask

    task automatic rx_case(input logic [7:0] v, input logic [1:0] p, input logic c8,
                           input logic [10:0] flip, input logic [31:0] st, input logic [31:0] irq);
        int k;
        k = rx_irqs;
        rx_send(v, p, c8, flip);
        repeat (4) @(posedge sys_clk);
        chk("rx_irq", 32'(rx_irqs - k), irq);
        rd(5'h0C, st);
        rd(5'h08, c8 ? {24'h0, v} : {25'h0, v[6:0]});
    endtask

    always @(posedge sys_clk) begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0) chk("readdata", avs_readdata, rdq.pop_front());
        if (got_stb === 1'b1) chk("tx_frame", {21'h0, got}, {21'h0, txq.pop_front()});
        if (rx_done_irq === 1'b1) rx_irqs <= rx_irqs + 1;
        if (tx_done_irq === 1'b1) tx_irqs <= tx_irqs + 1;
    end

    // ----------
    // scenarios
    // ----------
    initial begin
        void'($urandom(32'hFE63));
        rst_n = 1'b0;
        avs_address = 5'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        nbits = 4'h0;
        hold = 1'b0;
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
        rd(5'h00, 32'h8);
        rd(5'h10, 32'h8);
        wr(5'h10, 32'h8);
        for (int p = 0; p < 4; p++) begin
            d = 8'($urandom);
            wr(5'h00, 32'h48 | (p << 4));
            tx_case(d, p[1:0], 1'b1);
            rx_case(d, p[1:0], 1'b1, 11'h0, 32'h0, 32'h1);
            rx_case(~d, p[1:0], 1'b1, 11'h100, (p == 0) ? 32'h2 : (p == 1) ? 32'h0 : 32'h4, 32'h1);
        end
        d = 8'($urandom) | 8'h80;
        // external bit clock keeps running through a stopped internal clock
        wr(5'h10, 32'h8008);
        hold <= 1'b1;
        wr(5'h00, 32'h74);
        tx_case(d, 2'h3, 1'b0);
        rx_case(d, 2'h3, 1'b0, 11'h0, 32'h0, 32'h1);
        hold <= 1'b0;
        wr(5'h10, 32'h8);
        wr(5'h00, 32'h4A);
        rx_case(d, 2'h0, 1'b1, 11'h100, 32'h2, 32'h0);
        wr(5'h00, 32'h48);
        rx_send(d, 2'h0, 1'b1, 11'h0);
        rx_case(~d, 2'h0, 1'b1, 11'h0, 32'h1, 32'h1);
        rd(5'h0C, 32'h0);
        // a stopped internal clock freezes the receiver, so this frame is not taken
        hold <= 1'b1;
        c = rx_irqs;
        rx_send(8'hA5, 2'h0, 1'b1, 11'h0);
        repeat (4) @(posedge sys_clk);
        chk("hold_irq", 32'(rx_irqs - c), 32'h0);
        hold <= 1'b0;
        c = rx_irqs;
        fork
            rx_send(8'h5A, 2'h0, 1'b1, 11'h0);
            begin
                repeat (60) @(posedge sys_clk);
                wr(5'h00, 32'h08);
            end
        join
        repeat (4) @(posedge sys_clk);
        chk("abort_irq", 32'(rx_irqs - c), 32'h0);
        rd(5'h0C, 32'h0);
        rd(5'h08, {24'h0, ~d});
        rd(5'h14, 32'h3);
        wr(5'h14, 32'h3);
        rd(5'h14, 32'h0);
        rd(5'h18, 32'h0);
        chk("tx_left", 32'(txq.size()), 32'h0);
        finish_test();
    end

    initial begin
        repeat (30000) @(posedge sys_clk);
        error_cnt++;
        finish_test();
    end
endmodule // tb_async_serial_tx_rx_errors
`default_nettype wire
